// *** core/pin_mux_consts.svh ***
/*
 * constants for the port a/b alternate function override logic.
 * assumes inclusion by bare name from the design file.
 */
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// ************************************************************
// default pull-up pattern {dir, port, global off}
// ************************************************************
`define PULLUP_DEFAULT_PATTERN 3'h2

// ************************************************************
// pin positions
// ************************************************************
`define MISO_PIN 3
`define MOSI_PIN 2
`define SCK_PIN 1
`define SEL_PIN 0
`define SEG_LOW_PIN 4

// ************************************************************
// duty select thresholds for backplane pins 1..3
// ************************************************************
`define DUTY_ABOVE_PIN1 2'h0
`define DUTY_ABOVE_PIN2 2'h1
`define DUTY_ABOVE_PIN3 2'h2

// ************************************************************
// reset value of the input synchronisers
// ************************************************************
`define SYNC_RESET_VAL 8'hFF

`endif

// *** core/pin_mux_pkg.sv ***
/*
 * types shared by the port a/b alternate function override logic.
 * assumes nothing beyond a systemverilog compiler.
 */
package pin_mux_pkg;
  typedef logic [7:0] port_vec_t;
  typedef logic [1:0] duty_t;
  typedef logic [3:0] nibble_t;
endpackage

// *** core/port_ab_alternate_function_mux.sv ***
/*
 * override logic between port a/b registers, pads and the display,
 * timer, spi and pin-change modules.
 * assumes port registers, pads and peripherals sit on mclk_i; pad
 * inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`include "pin_mux_consts.svh"

module port_ab_alternate_function_mux
  import pin_mux_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire port_vec_t dir_a_i,
  input wire port_vec_t port_out_a_i,
  input wire port_vec_t dir_b_i,
  input wire port_vec_t port_out_b_i,
  input wire port_vec_t pad_b_i,
  input wire logic global_pullup_off_i,
  input wire logic sleep_i,
  input wire logic display_driver_on_i,
  input wire duty_t display_duty_select_i,
  input wire nibble_t compare_en_i,
  input wire logic compare_out_t2_a_i,
  input wire logic compare_out_t1_b_i,
  input wire logic compare_out_t1_a_i,
  input wire logic compare_out_t0_a_i,
  input wire port_vec_t pin_change_source_i,
  input wire logic pin_change_group1_on_i,
  input wire logic serial_periph_on_i,
  input wire logic controller_select_i,
  input wire logic spi_slave_data_i,
  input wire logic spi_master_data_i,
  input wire logic spi_sck_gen_i,
  output logic [7:0] pullup_a_o,
  output logic [7:0] drive_en_a_o,
  output logic [7:0] pad_out_a_o,
  output logic [7:0] input_en_a_o,
  output logic [3:0] segment_line_o,
  output logic [3:0] backplane_line_o,
  output logic [7:0] pullup_b_o,
  output logic [7:0] drive_en_b_o,
  output logic [7:0] pad_out_b_o,
  output logic [7:0] input_en_b_o,
  output logic [7:0] pin_change_in_o,
  output logic spi_master_in_o,
  output logic spi_slave_in_o,
  output logic spi_sck_in_o,
  output logic spi_select_n_o,
  output logic spi_slave_active_o
);

  // ************************************************************
  // override signals
  // ************************************************************
  port_vec_t pu_oe_a, pu_ov_a, dd_oe_a, dd_ov_a, pv_oe_a, pv_ov_a, ie_oe_a, ie_ov_a;
  port_vec_t pu_oe_b, pu_ov_b, dd_oe_b, dd_ov_b, pv_oe_b, pv_ov_b, ie_oe_b, ie_ov_b;
  port_vec_t pad_b_meta_reg, pad_b_sync_reg;
  logic spi_master, spi_slave;
  nibble_t com_on, cmp_val;

  assign spi_master = serial_periph_on_i & controller_select_i;
  assign spi_slave = serial_periph_on_i & ~controller_select_i;
  assign cmp_val = {compare_out_t2_a_i, compare_out_t1_b_i, compare_out_t1_a_i,
                    compare_out_t0_a_i};

  // backplane pins beyond the selected duty stay ordinary port pins
  assign com_on[3] = display_driver_on_i & (display_duty_select_i > `DUTY_ABOVE_PIN3);
  assign com_on[2] = display_driver_on_i & (display_duty_select_i > `DUTY_ABOVE_PIN2);
  assign com_on[1] = display_driver_on_i & (display_duty_select_i > `DUTY_ABOVE_PIN1);
  assign com_on[0] = display_driver_on_i;

  // ************************************************************
  // port a: display segments and backplanes
  // ************************************************************
  always_comb begin
    pu_oe_a = {{4{display_driver_on_i}}, com_on};
    dd_oe_a = {{4{display_driver_on_i}}, com_on};
    ie_oe_a = {{4{display_driver_on_i}}, com_on};
    pu_ov_a = 8'h00;
    dd_ov_a = 8'h00;
    ie_ov_a = 8'h00;
    pv_oe_a = 8'h00;
    pv_ov_a = 8'h00;
  end

  // analog path connects whenever the pin is handed to the display
  assign segment_line_o = {4{display_driver_on_i}};
  assign backplane_line_o = com_on;

  // ************************************************************
  // port b: compare outputs, pin change, spi
  // ************************************************************
  always_comb begin
    pu_oe_b = 8'h00;
    pu_ov_b = 8'h00;
    dd_oe_b = 8'h00;
    dd_ov_b = 8'h00;
    pv_oe_b = {compare_en_i, 4'h0};
    pv_ov_b = {cmp_val, 4'h0};
    // forced spi inputs: driver off, pull-up from port bit and global off
    dd_oe_b[`MISO_PIN] = spi_master;
    dd_oe_b[`MOSI_PIN] = spi_slave;
    dd_oe_b[`SCK_PIN] = spi_slave;
    dd_oe_b[`SEL_PIN] = spi_slave;
    pu_oe_b[3:0] = dd_oe_b[3:0];
    pu_ov_b[3:0] = port_out_b_i[3:0] & {4{~global_pullup_off_i}};
    pv_oe_b[`MISO_PIN] = serial_periph_on_i;
    pv_ov_b[`MISO_PIN] = spi_slave_data_i;
    pv_oe_b[`MOSI_PIN] = spi_master;
    pv_ov_b[`MOSI_PIN] = spi_master_data_i;
    pv_oe_b[`SCK_PIN] = spi_master;
    pv_ov_b[`SCK_PIN] = spi_sck_gen_i;
    ie_oe_b = pin_change_source_i & {8{pin_change_group1_on_i}};
    ie_ov_b = 8'hFF;
  end

  // ************************************************************
  // generic pin resolution, combinational throughout
  // ************************************************************
  // no register here: a display or spi enable reaches the pad at once
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pullup_a_o[i] = pu_oe_a[i] ? pu_ov_a[i] :
        ({dir_a_i[i], port_out_a_i[i], global_pullup_off_i} == `PULLUP_DEFAULT_PATTERN);
      pullup_b_o[i] = pu_oe_b[i] ? pu_ov_b[i] :
        ({dir_b_i[i], port_out_b_i[i], global_pullup_off_i} == `PULLUP_DEFAULT_PATTERN);
    end
    drive_en_a_o = (dd_oe_a & dd_ov_a) | (~dd_oe_a & dir_a_i);
    drive_en_b_o = (dd_oe_b & dd_ov_b) | (~dd_oe_b & dir_b_i);
    pad_out_a_o = (pv_oe_a & pv_ov_a) | (~pv_oe_a & port_out_a_i);
    pad_out_b_o = (pv_oe_b & pv_ov_b) | (~pv_oe_b & port_out_b_i);
    input_en_a_o = (ie_oe_a & ie_ov_a) | (~ie_oe_a & {8{~sleep_i}});
    input_en_b_o = (ie_oe_b & ie_ov_b) | (~ie_oe_b & {8{~sleep_i}});
  end

  // ************************************************************
  // pad input synchroniser
  // ************************************************************
  // resets high so spi select reads idle until the pad is seen
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pad_b_meta_reg <= `SYNC_RESET_VAL;
      pad_b_sync_reg <= `SYNC_RESET_VAL;
    end else if (clk_en_i) begin
      pad_b_meta_reg <= pad_b_i;
      pad_b_sync_reg <= pad_b_meta_reg;
    end
  end

  // clamped pin-change inputs read low, as at the pin's input stage; the spi inputs take the synchronised pad unmasked
  assign pin_change_in_o = pad_b_sync_reg & input_en_b_o;
  assign spi_master_in_o = pad_b_sync_reg[`MISO_PIN];
  assign spi_slave_in_o = pad_b_sync_reg[`MOSI_PIN];
  assign spi_sck_in_o = pad_b_sync_reg[`SCK_PIN];
  assign spi_select_n_o = pad_b_sync_reg[`SEL_PIN];
  assign spi_slave_active_o = spi_slave & ~pad_b_sync_reg[`SEL_PIN];

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  seg_pins_off_a: assert property (display_driver_on_i |->
    (pullup_a_o[7:4] == 4'h0 && drive_en_a_o[7:4] == 4'h0 && input_en_a_o[7:4] == 4'h0))
    else $error("segment pin not released to display");
  com_duty_a: assert property (
    (display_driver_on_i && display_duty_select_i == 2'h1) |->
    (drive_en_a_o[2:1] == {dir_a_i[2], 1'b0} && backplane_line_o == 4'h3))
    else $error("backplane duty gating wrong");
  cmp_drive_a: assert property (compare_en_i[3] |->
    pad_out_b_o[7] == compare_out_t2_a_i)
    else $error("compare output not on pad");
  cmp_dir_a: assert property (drive_en_b_o[7:4] == dir_b_i[7:4])
    else $error("compare pin direction overridden");
  pc_keep_a: assert property ((pin_change_group1_on_i && sleep_i) |->
    input_en_b_o == (pin_change_source_i | 8'h00))
    else $error("pin change input not kept alive");
  miso_in_a: assert property (spi_master |-> !drive_en_b_o[`MISO_PIN])
    else $error("miso driven as master");
  mosi_in_a: assert property (spi_slave |->
    !drive_en_b_o[`MOSI_PIN] && !drive_en_b_o[`SCK_PIN])
    else $error("mosi or sck driven as slave");
  sck_out_a: assert property (spi_master |->
    pad_out_b_o[`SCK_PIN] == spi_sck_gen_i)
    else $error("generated clock missing");
  spi_pull_a: assert property (spi_slave |->
    pullup_b_o[`SEL_PIN] == (port_out_b_i[`SEL_PIN] & ~global_pullup_off_i))
    else $error("forced input pull-up wrong");
  // pad level two enabled edges back; the first stage stays private to the synchroniser
  slave_act_a: assert property ((clk_en_i [*3]) ##0 spi_slave |->
    spi_slave_active_o == !$past(pad_b_i[`SEL_PIN], 2))
    else $error("slave active not tied to select");
  dflt_pull_a: assert property ((!display_driver_on_i && !global_pullup_off_i) |->
    pullup_a_o == (~dir_a_i & port_out_a_i))
    else $error("default pull-up wrong");

  display_c: cover property (display_driver_on_i && display_duty_select_i == 2'h3);
  compare_c: cover property (compare_en_i == 4'hF);
  master_c: cover property (spi_master ##1 !spi_master);
  slave_c: cover property (spi_slave_active_o [*3]);
endmodule

// *** bench/periph_stub.sv ***
/* stand-in for the timer and spi modules that feed the override logic.
   assumes the bench's clock and reset. */
`timescale 1ns/1ps
module periph_stub (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  output logic [3:0] wave_o,
  output logic [2:0] spi_o
);
  logic [3:0] phase_reg;
  // ********
  // free-running phases; the wave bits differ in rate, while spi_o reuses phase bits 1 and 0
  // ********
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end
  assign wave_o = phase_reg ^ 4'h5;
  assign spi_o = {phase_reg[1], ~phase_reg[1], phase_reg[0]};
endmodule

// *** bench/port_ab_alternate_function_mux_tb.sv ***
/* self-checking bench for the port a/b override logic.
   assumes the peripheral stand-in drives the timer and spi inputs. */
`timescale 1ns/1ps
module port_ab_alternate_function_mux_tb;
  import pin_mux_pkg::*;
  logic mclk_i, reset_n_i, clk_en_i, global_pullup_off_i, sleep_i, display_driver_on_i;
  logic pin_change_group1_on_i, serial_periph_on_i, controller_select_i;
  port_vec_t dir_a_i, port_out_a_i, dir_b_i, port_out_b_i, pad_b_i, pin_change_source_i;
  duty_t display_duty_select_i;
  nibble_t compare_en_i, wave;
  logic [2:0] spi;
  logic [7:0] pullup_a_o, drive_en_a_o, pad_out_a_o, input_en_a_o, pullup_b_o, drive_en_b_o;
  logic [7:0] pad_out_b_o, input_en_b_o, pin_change_in_o;
  logic [3:0] segment_line_o, backplane_line_o;
  logic spi_master_in_o, spi_slave_in_o, spi_sck_in_o, spi_select_n_o, spi_slave_active_o;
  int bad_count = 0;
  int checked = 0;
  periph_stub peer_u (.mclk_i, .reset_n_i, .wave_o(wave), .spi_o(spi));
  port_ab_alternate_function_mux dut_u (.mclk_i, .reset_n_i, .clk_en_i, .dir_a_i, .port_out_a_i,
    .dir_b_i, .port_out_b_i, .pad_b_i, .global_pullup_off_i, .sleep_i, .display_driver_on_i,
    .display_duty_select_i, .compare_en_i, .compare_out_t2_a_i(wave[3]),
    .compare_out_t1_b_i(wave[2]), .compare_out_t1_a_i(wave[1]), .compare_out_t0_a_i(wave[0]),
    .pin_change_source_i, .pin_change_group1_on_i, .serial_periph_on_i, .controller_select_i,
    .spi_slave_data_i(spi[2]), .spi_master_data_i(spi[1]), .spi_sck_gen_i(spi[0]), .pullup_a_o,
    .drive_en_a_o, .pad_out_a_o, .input_en_a_o, .segment_line_o, .backplane_line_o, .pullup_b_o,
    .drive_en_b_o, .pad_out_b_o, .input_en_b_o, .pin_change_in_o, .spi_master_in_o,
    .spi_slave_in_o, .spi_sck_in_o, .spi_select_n_o, .spi_slave_active_o);
  // ********
  // shared helpers
  // ********
  task automatic chk(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic port_vec_t pu(port_vec_t d, port_vec_t p);
    return ~d & p & {8{~global_pullup_off_i}};
  endfunction
  // ********
  // scenarios
  // ********
  task automatic plain_io();
    port_vec_t pat [4] = '{8'h0F, 8'h3C, 8'hA5, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      {dir_a_i, dir_b_i, port_out_a_i, port_out_b_i} <= {pat[i], pat[i], pat[3-i], pat[3-i]};
      {global_pullup_off_i, sleep_i} <= {i[0], i[1]};
      @(negedge mclk_i);
      chk(pullup_a_o === pu(dir_a_i, port_out_a_i), "pull-up default a");
      chk(pullup_b_o === pu(dir_b_i, port_out_b_i), "pull-up default b");
      chk(drive_en_a_o === dir_a_i && drive_en_b_o === dir_b_i, "direction");
      chk(pad_out_a_o === port_out_a_i && pad_out_b_o === port_out_b_i, "pad value");
      chk(input_en_a_o === {8{~sleep_i}} && input_en_b_o === {8{~sleep_i}}, "sleep");
    end
  endtask
  task automatic display_cover();
    port_vec_t m;
    for (int d = 0; d < 4; d++) begin
      @(posedge mclk_i);
      {dir_a_i, port_out_a_i, global_pullup_off_i, sleep_i} <= {8'hAA, 8'hFF, 2'b00};
      {display_driver_on_i, display_duty_select_i} <= {1'b1, d[1:0]};
      @(negedge mclk_i);
      m = {4'hF, d > 2, d > 1, d > 0, 1'b1};
      chk(pullup_a_o === (8'h55 & ~m) && drive_en_a_o === (8'hAA & ~m), "display");
      chk(input_en_a_o === ~m, "display input clamp");
      chk(segment_line_o === 4'hF && backplane_line_o === m[3:0], "routing");
    end
    @(posedge mclk_i);
    display_driver_on_i <= 1'b0;
    @(negedge mclk_i);
    chk(segment_line_o === 4'h0 && drive_en_a_o === 8'hAA, "display off");
  endtask
  task automatic compare_out();
    nibble_t en [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_i);
      {dir_b_i, port_out_b_i, compare_en_i} <= {8'hF0, 8'h50, en[i]};
      repeat (4) begin
        @(negedge mclk_i);
        chk(pad_out_b_o[7:4] === ((en[i] & wave) | (~en[i] & 4'h5)), "compare");
        chk(drive_en_b_o === 8'hF0 && pullup_b_o === 8'h00, "compare override");
      end
    end
    @(posedge mclk_i);
    compare_en_i <= 4'h0;
  endtask
  task automatic pin_change();
    for (int g = 0; g < 2; g++) begin
      @(posedge mclk_i);
      {sleep_i, pin_change_group1_on_i, pin_change_source_i} <= {1'b1, g[0], 8'h5A};
      @(negedge mclk_i);
      chk(input_en_b_o === (g ? 8'h5A : 8'h00), "pin change enable");
    end
  endtask
  task automatic spi_pins();
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk_i);
      {serial_periph_on_i, controller_select_i, global_pullup_off_i} <= {1'b1, m == 1, m == 2};
      {dir_b_i, port_out_b_i, sleep_i, pin_change_group1_on_i} <= {8'h0F, 8'h0F, 2'b00};
      repeat (2) begin
        @(negedge mclk_i);
        if (m == 1) begin
          chk(drive_en_b_o[3:0] === 4'h7 && pullup_b_o[3] === 1'b1, "master");
          chk(pad_out_b_o[2:0] === {spi[1], spi[0], 1'b1}, "master out");
        end else begin
          chk(drive_en_b_o[3:0] === 4'h8 && pad_out_b_o[3] === spi[2], "slave");
          chk(pullup_b_o[2:0] === (m == 2 ? 3'h0 : 3'h7), "forced pull-up");
        end
      end
    end
  endtask
  task automatic pad_sync();
    @(posedge mclk_i);
    {controller_select_i, clk_en_i, pad_b_i} <= {2'b01, 8'hF6};
    repeat (2) @(negedge mclk_i);
    chk(spi_select_n_o === 1'b1, "select early");
    @(negedge mclk_i);
    chk(spi_select_n_o === 1'b0 && spi_slave_active_o === 1'b1, "selected");
    chk({spi_master_in_o, spi_slave_in_o, spi_sck_in_o} === 3'b011, "spi inputs");
    chk(pin_change_in_o === 8'hF6, "pin change inputs");
    @(posedge mclk_i);
    {clk_en_i, controller_select_i, pad_b_i} <= {2'b01, 8'hFF};
    repeat (3) @(negedge mclk_i);
    chk(spi_select_n_o === 1'b0 && spi_slave_active_o === 1'b0, "frozen");
    @(posedge mclk_i);
    clk_en_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk(spi_select_n_o === 1'b1, "released");
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // hang guard, far beyond the fewer than a hundred cycles the run needs
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
  initial begin
    {reset_n_i, clk_en_i, global_pullup_off_i, sleep_i, display_driver_on_i} = 5'b01000;
    {pin_change_group1_on_i, serial_periph_on_i, controller_select_i} = 3'b000;
    {display_duty_select_i, compare_en_i, pad_b_i} = 14'h00FF;
    {dir_a_i, port_out_a_i, dir_b_i, port_out_b_i, pin_change_source_i} = 40'h0;
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    plain_io();
    display_cover();
    compare_out();
    pin_change();
    spi_pins();
    pad_sync();
    close_out();
  end
endmodule
